//--- src/wwdr_pkg.sv
// package: register map, field layout, reset values and timing counts of the watchdog read-back
`default_nettype none
package wwdr_pkg;
    // register offsets (byte addresses on the register port)
    localparam logic [3:0] ADDR_CTRL0     = 4'h0;
    localparam logic [3:0] ADDR_CTRL1     = 4'h1;
    localparam logic [3:0] ADDR_PS_LOW    = 4'h2;
    localparam logic [3:0] ADDR_PS_HIGH   = 4'h3;
    localparam logic [3:0] ADDR_WIN_TMR   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h6;
    localparam logic [3:0] ADDR_CLEAR_CMD = 4'h7;

    // control register 0: enable in bit 0, prescale select in bits 5:1
    localparam int CTRL0_EN_BIT = 0;
    localparam int CTRL0_PS_LSB = 1;
    localparam int CTRL0_PS_MSB = 5;
    // control register 1: window select in bits 2:0, clock select in bits 6:4
    localparam int CTRL1_WIN_LSB = 0;
    localparam int CTRL1_WIN_MSB = 2;
    localparam int CTRL1_CS_LSB  = 4;
    localparam int CTRL1_CS_MSB  = 6;
    // window timer register layout
    localparam int WTMR_PS_LSB    = 0;
    localparam int WTMR_PS_MSB    = 1;
    localparam int WTMR_ARMED_BIT = 2;
    localparam int WTMR_WIN_LSB   = 3;
    localparam int WTMR_WIN_MSB   = 7;
    // interrupt event bits
    localparam int EV_TIMEOUT = 0;
    localparam int EV_EARLY   = 1;
    localparam int EV_OPENED  = 2;
    localparam int EV_W       = 3;
    // clear command bit
    localparam int CLEAR_CMD_BIT = 0;

    localparam int PS_CNT_W  = 18;
    localparam int WIN_CNT_W = 5;

    // reset values
    localparam logic [4:0] PS_SEL_RESET  = 5'h0b;
    localparam logic [2:0] WIN_SEL_RESET = 3'h7;
    localparam logic [2:0] CS_SEL_RESET  = 3'h0;
    localparam logic       EN_RESET      = 1'b0;
    localparam logic [7:0] STAT_RESET    = 8'h00;

    // prescale select: largest defined code, power of two up to 2^18 on the prescaler
    localparam logic [4:0] PS_SEL_MAX = 5'h12;
    localparam logic [2:0] WIN_SEL_ALL_OPEN = 3'h7;

    typedef enum logic [2:0] {
        WWDR_CS_LOW_FREQ_INTERNAL_OSC = 3'h0,
        WWDR_CS_MID_FREQ_INTERNAL_OSC = 3'h1,
        WWDR_CS_SECOSC   = 3'h2
    } wwdr_clk_sel_t;

    // timing: system clock and watchdog clock sources
    localparam longint CLK_HZ     = 200_000_000;
    localparam longint LF_OSC_HZ  = 31_000;
    localparam longint MF_OSC_HZ  = 31_250;
    localparam int     LF_DIV_CYC = int'(CLK_HZ / LF_OSC_HZ);
    localparam int     MF_DIV_CYC = int'(CLK_HZ / MF_OSC_HZ);
    localparam int     DIV_W      = 13;
endpackage : wwdr_pkg
`default_nettype wire

//--- src/wwdr_tick_gen.sv
// module: divider that turns the system clock into one-cycle watchdog clock enables
`default_nettype none
module wwdr_tick_gen
    import wwdr_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] period,
    output logic                  tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    wire              at_end = (cnt_q >= period - DIV_W'(1));

    assign cnt_d = (restart || at_end) ? '0 : cnt_q + DIV_W'(1);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= at_end && !restart;
        end
    end
endmodule // wwdr_tick_gen
`default_nettype wire

//--- src/wwdr_top.sv
// module: windowed watchdog counters, window evaluation and read-only status registers
//
// Implementation choices: strobed register access and the register offsets.
`default_nettype none
module wwdr_top
    import wwdr_pkg::*;
#(
    parameter int LF_DIV = LF_DIV_CYC,
    parameter int MF_DIV = MF_DIV_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       sec_osc_in,
    input  wire logic       wdt_clear_in,
    output logic            timeout_pulse,
    output logic            window_open,
    output logic            irq
);

    // effective prescale exponent; reserved codes fall back to the minimum interval
    function automatic logic [4:0] ps_exp(input logic [4:0] sel);
        ps_exp = (sel > PS_SEL_MAX) ? 5'h00 : sel;
    endfunction

    // mask of prescale bits that must all be one for the window count to step
    function automatic logic [PS_CNT_W-1:0] ps_mask(input logic [4:0] sel);
        logic [PS_CNT_W:0] one_hot;
        one_hot = '0;
        one_hot[ps_exp(sel)] = 1'b1;
        ps_mask = PS_CNT_W'(one_hot - (PS_CNT_W + 1)'(1));
    endfunction

    // window open test, shared by the live output and the opening event
    function automatic logic win_is_open(input logic [WIN_CNT_W-1:0] win,
                                         input logic [2:0]           sel);
        logic [WIN_CNT_W-1:0] edge_cnt;
        edge_cnt = {(3'h7 - sel), 2'b00};
        win_is_open = (sel == WIN_SEL_ALL_OPEN) || (win >= edge_cnt);
    endfunction

    // control state
    logic                 en_q;
    logic [4:0]           ps_sel_q;
    logic [2:0]           win_sel_q;
    logic [2:0]           cs_sel_q;
    logic [EV_W-1:0]      stat_q;
    logic [EV_W-1:0]      mask_q;

    // counters
    logic [PS_CNT_W-1:0]  prescale_count_q;
    logic [PS_CNT_W-1:0]  prescale_count_d;
    logic [WIN_CNT_W-1:0] window_count_q;
    logic [WIN_CNT_W-1:0] window_count_d;
    logic                 open_prev_q;
    logic                 timeout_q;
    logic [7:0]           rdata_q;
    logic                 sec_osc_q;

    // register port decode
    wire wr_ctrl0  = reg_wr && (reg_addr == ADDR_CTRL0);
    wire wr_ctrl1  = reg_wr && (reg_addr == ADDR_CTRL1);
    wire wr_stat   = reg_wr && (reg_addr == ADDR_IRQ_STAT);
    wire wr_mask   = reg_wr && (reg_addr == ADDR_IRQ_MASK);
    wire wr_clear  = reg_wr && (reg_addr == ADDR_CLEAR_CMD)
                     && reg_wdata[CLEAR_CMD_BIT];

    // watchdog clock: two internal sources divided down, or edges of the secondary osc
    logic [DIV_W-1:0] div_period;
    logic             div_tick;
    wire              cs_change = wr_ctrl1
                      && (reg_wdata[CTRL1_CS_MSB:CTRL1_CS_LSB] != cs_sel_q);
    wire              sec_osc_rise = sec_osc_in && !sec_osc_q;

    assign div_period = (cs_sel_q == WWDR_CS_MID_FREQ_INTERNAL_OSC) ? DIV_W'(MF_DIV)
                                                       : DIV_W'(LF_DIV);

    wwdr_tick_gen u_tick_gen (
        .ref_clk (ref_clk),
        .rst     (rst),
        .restart (cs_change),
        .period  (div_period),
        .tick    (div_tick)
    );

    // reserved clock codes leave the watchdog without a clock
    logic wd_tick;
    always_comb begin
        unique case (cs_sel_q)
            WWDR_CS_LOW_FREQ_INTERNAL_OSC: wd_tick = div_tick;
            WWDR_CS_MID_FREQ_INTERNAL_OSC: wd_tick = div_tick;
            WWDR_CS_SECOSC:   wd_tick = sec_osc_rise;
            default:          wd_tick = 1'b0;
        endcase
    end

    // counting
    wire wd_clear  = wr_clear || wdt_clear_in;
    wire step      = en_q && wd_tick;
    wire ps_hit    = (prescale_count_q & ps_mask(ps_sel_q)) == ps_mask(ps_sel_q);
    wire win_step  = step && ps_hit;
    wire win_wrap  = win_step && (&window_count_q);

    always_comb begin
        prescale_count_d = prescale_count_q;
        window_count_d   = window_count_q;
        if (wd_clear || !en_q) begin
            prescale_count_d = '0;
            window_count_d   = '0;
        end else if (win_step) begin
            prescale_count_d = '0;
            window_count_d   = window_count_q + WIN_CNT_W'(1);
        end else if (step) begin
            prescale_count_d = prescale_count_q + PS_CNT_W'(1);
        end
    end

    // open state is combinational from the counter so it moves with it
    wire open_now = win_is_open(window_count_q, win_sel_q);
    wire armed    = en_q && open_now;

    // events: a hardware set wins over a same-cycle write-one-to-clear
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] stat_d;
    assign ev_set[EV_TIMEOUT] = win_wrap && !wd_clear;
    assign ev_set[EV_EARLY]   = wd_clear && en_q && !open_now;
    assign ev_set[EV_OPENED]  = en_q && open_now && !open_prev_q;
    assign stat_d = ev_set | (stat_q & ~(wr_stat ? reg_wdata[EV_W-1:0] : '0));

    // read-back images; writes to these three offsets are ignored
    wire [7:0] ps_low_img  = prescale_count_q[7:0];
    wire [7:0] ps_high_img = prescale_count_q[15:8];
    logic [7:0] win_tmr_img;
    always_comb begin
        win_tmr_img = '0;
        win_tmr_img[WTMR_WIN_MSB:WTMR_WIN_LSB] = window_count_q;
        win_tmr_img[WTMR_ARMED_BIT]            = armed;
        win_tmr_img[WTMR_PS_MSB:WTMR_PS_LSB]   = prescale_count_q[17:16];
    end

    logic [7:0] ctrl0_img;
    logic [7:0] ctrl1_img;
    always_comb begin
        ctrl0_img = '0;
        ctrl0_img[CTRL0_EN_BIT] = en_q;
        ctrl0_img[CTRL0_PS_MSB:CTRL0_PS_LSB] = ps_sel_q;
        ctrl1_img = '0;
        ctrl1_img[CTRL1_WIN_MSB:CTRL1_WIN_LSB] = win_sel_q;
        ctrl1_img[CTRL1_CS_MSB:CTRL1_CS_LSB]   = cs_sel_q;
    end

    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            ADDR_CTRL0:    rd_mux = ctrl0_img;
            ADDR_CTRL1:    rd_mux = ctrl1_img;
            ADDR_PS_LOW:   rd_mux = ps_low_img;
            ADDR_PS_HIGH:  rd_mux = ps_high_img;
            ADDR_WIN_TMR:  rd_mux = win_tmr_img;
            ADDR_IRQ_STAT: rd_mux = {{(8 - EV_W){1'b0}}, stat_q};
            ADDR_IRQ_MASK: rd_mux = {{(8 - EV_W){1'b0}}, mask_q};
            default:       rd_mux = 8'h00;
        endcase
    end

    // control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_q      <= EN_RESET;
            ps_sel_q  <= PS_SEL_RESET;
            win_sel_q <= WIN_SEL_RESET;
            cs_sel_q  <= CS_SEL_RESET;
            mask_q    <= '0;
        end else begin
            if (wr_ctrl0) begin
                en_q     <= reg_wdata[CTRL0_EN_BIT];
                ps_sel_q <= reg_wdata[CTRL0_PS_MSB:CTRL0_PS_LSB];
            end
            if (wr_ctrl1) begin
                win_sel_q <= reg_wdata[CTRL1_WIN_MSB:CTRL1_WIN_LSB];
                cs_sel_q  <= reg_wdata[CTRL1_CS_MSB:CTRL1_CS_LSB];
            end
            if (wr_mask) begin
                mask_q <= reg_wdata[EV_W-1:0];
            end
        end
    end

    // counters and status; every reset returns the read-only images to zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prescale_count_q <= '0;
            window_count_q   <= '0;
            open_prev_q      <= 1'b0;
            stat_q           <= STAT_RESET[EV_W-1:0];
            timeout_q        <= 1'b0;
            sec_osc_q        <= 1'b0;
        end else begin
            prescale_count_q <= prescale_count_d;
            window_count_q   <= window_count_d;
            open_prev_q      <= en_q && open_now;
            stat_q           <= stat_d;
            timeout_q        <= ev_set[EV_TIMEOUT];
            sec_osc_q        <= sec_osc_in;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata     = rdata_q;
    assign timeout_pulse = timeout_q;
    assign window_open   = armed;
    assign irq           = |(stat_q & mask_q);

endmodule // wwdr_top
`default_nettype wire

//--- dv/wwdr_asserts.sv
// checker: port-level properties of the watchdog read-back block
`default_nettype none
module wwdr_asserts
    import wwdr_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       wdt_clear_in,
    input wire logic       timeout_pulse,
    input wire logic       window_open,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       en_q;
    logic [2:0] sel_q;
    logic [7:0] mask_q;
    // shadow of control writes, updated on the same edge as the design's own copy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_q   <= EN_RESET;
            sel_q  <= WIN_SEL_RESET;
            mask_q <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CTRL0) en_q <= reg_wdata[CTRL0_EN_BIT];
            if (reg_addr == ADDR_CTRL1) sel_q <= reg_wdata[CTRL1_WIN_MSB:CTRL1_WIN_LSB];
            if (reg_addr == ADDR_IRQ_MASK) mask_q <= reg_wdata;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    property p_armed_bit;
        reg_rd && reg_addr == ADDR_WIN_TMR |=> reg_rdata[WTMR_ARMED_BIT] == $past(window_open);
    endproperty
    a_armed_bit: assert property (p_armed_bit)
        else $error("armed bit differs from window state");
    property p_all_open; en_q && sel_q == WIN_SEL_ALL_OPEN |-> window_open; endproperty
    a_all_open: assert property (p_all_open)
        else $error("window closed with all-open select");
    property p_off_closed; !en_q |-> !window_open; endproperty
    a_off_closed: assert property (p_off_closed)
        else $error("window open while disabled");
    property p_clear_closes;
        wdt_clear_in && en_q && sel_q != WIN_SEL_ALL_OPEN && !reg_wr |=> !window_open;
    endproperty
    a_clear_closes: assert property (p_clear_closes)
        else $error("window open right after a clear");
    property p_clear_no_to; wdt_clear_in |=> !timeout_pulse; endproperty
    a_clear_no_to: assert property (p_clear_no_to)
        else $error("timeout despite clear");
    property p_pulse_one; timeout_pulse |=> !timeout_pulse [*8]; endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("timeout pulse too long");
    property p_to_closed; timeout_pulse && sel_q != WIN_SEL_ALL_OPEN |-> !window_open; endproperty
    a_to_closed: assert property (p_to_closed)
        else $error("window open after wrap");
    property p_off_no_to; !en_q |=> !timeout_pulse; endproperty
    a_off_no_to: assert property (p_off_no_to)
        else $error("timeout while disabled");
    property p_to_irq; timeout_pulse && mask_q[EV_TIMEOUT] |-> irq; endproperty
    a_to_irq: assert property (p_to_irq)
        else $error("unmasked timeout without irq");
endmodule // wwdr_asserts
`default_nettype wire

//--- dv/testbench.sv
// testbench: register-level scenarios for the watchdog read-back block
`default_nettype none
module testbench
    import wwdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       sec_osc_in = 1'b0;
    logic       wdt_clear_in = 1'b0;
    logic [7:0] reg_rdata;
    logic       timeout_pulse;
    logic       window_open;
    logic       irq;
    int         err_total = 0;
    int         comparisons = 0;
    int         tot = 0;
    int         n_to = 0;
    logic [4:0] ps;
    logic [2:0] sel;
    logic       en;
    // small dividers keep the free-running oscillator paths short
    wwdr_top #(.LF_DIV(4), .MF_DIV(4)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sec_osc_in(sec_osc_in),
        .wdt_clear_in(wdt_clear_in), .timeout_pulse(timeout_pulse),
        .window_open(window_open), .irq(irq));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (timeout_pulse === 1'b1) n_to <= n_to + 1;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // secondary oscillator as watchdog clock gives an exact tick count
    task automatic cfg(input logic [4:0] p, input logic [2:0] s, input logic e);
        ps = p;
        sel = s;
        en = e;
        wr(ADDR_CTRL1, {4'h2, 1'b0, s});
        wr(ADDR_CTRL0, {2'b00, p, e});
    endtask
    task automatic clr(input logic pin);
        if (pin) begin
            @(posedge ref_clk);
            wdt_clear_in <= 1'b1;
            @(posedge ref_clk);
            wdt_clear_in <= 1'b0;
        end else begin
            wr(ADDR_CLEAR_CMD, 8'h01);
        end
        tot = 0;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            sec_osc_in <= 1'b1;
            @(posedge ref_clk);
            sec_osc_in <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        tot += n;
    endtask
    task automatic chk_state();
        int          b;
        logic [17:0] pc;
        logic [4:0]  w;
        logic        open;
        // the window steps once per 2^code ticks, so 32 steps give the 2^(code+5) rate
        b = (ps > PS_SEL_MAX) ? 0 : int'(ps);
        pc = en ? 18'(tot % (1 << b)) : 18'h0;
        w = en ? 5'(tot >> b) : 5'h00;
        open = en && (w >= 4 * (7 - sel));
        rd(ADDR_PS_LOW, pc[7:0]);
        rd(ADDR_PS_HIGH, pc[15:8]);
        rd(ADDR_WIN_TMR, {w, open, pc[17:16]});
        chk(8'(window_open), 8'(open));
    endtask
    // divided clock: counts held at zero, source switched (restarts divider), enabled
    task automatic div_run(input logic [2:0] cs, input logic [7:0] exp);
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_CTRL1, {1'b0, cs, 4'h7});
        wr(ADDR_CTRL0, 8'h01);
        repeat (36) @(posedge ref_clk);
        rd(ADDR_WIN_TMR, exp);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 2; a < 5; a++) wr(4'(a), 8'hff);
        rd(ADDR_CTRL0, {2'b00, PS_SEL_RESET, EN_RESET});
        rd(ADDR_CTRL1, {1'b0, CS_SEL_RESET, 1'b0, WIN_SEL_RESET});
        for (int a = 2; a < 16; a++) begin
            if (a != 7) rd(4'(a), 8'h00);
        end
        for (int s = 0; s < 8; s++) begin
            cfg(5'h00, 3'(s), 1'b1);
            clr(s[0]);
            if (s < 7) begin
                // one tick short of the closed-to-open boundary
                tick(4 * (7 - s) - 1);
                chk_state();
            end
            tick(1);
            chk_state();
        end
        cfg(5'h04, 3'h3, 1'b1);
        clr(1'b0);
        tick(400);
        chk_state();
        cfg(5'h09, 3'h3, 1'b1);
        clr(1'b1);
        tick(300);
        chk_state();
        // reserved code steps like code 0; kept short of a wrap so no timeout is left
        cfg(5'h1f, 3'h3, 1'b1);
        clr(1'b0);
        tick(20);
        chk_state();
        cfg(5'h1f, 3'h3, 1'b0);
        chk_state();
        // divider of 4: nine ticks land before the read; a reserved source gives none
        div_run(3'h0, {5'd9, 1'b1, 2'b00});
        div_run(3'h1, {5'd9, 1'b1, 2'b00});
        div_run(3'h3, {5'd0, 1'b1, 2'b00});
        cfg(5'h00, 3'h0, 1'b1);
        wr(ADDR_IRQ_MASK, 8'h01);
        clr(1'b1);
        #1 chk(8'(irq), 8'h00);
        tick(32);
        chk(8'(n_to), 8'h01);
        chk(8'(irq), 8'h01);
        chk_state();
        rd(ADDR_IRQ_STAT, 8'h07);
        wr(ADDR_IRQ_STAT, 8'h01);
        #1 chk(8'(irq), 8'h00);
        wr(ADDR_IRQ_MASK, 8'h04);
        #1 chk(8'(irq), 8'h01);
        wr(ADDR_IRQ_STAT, 8'h06);
        #1 chk(8'(irq), 8'h00);
        rd(ADDR_IRQ_STAT, 8'h00);
        tick(40);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk(8'({irq, window_open, timeout_pulse}), 8'h00);
        rd(ADDR_PS_LOW, 8'h00);
        rd(ADDR_WIN_TMR, 8'h00);
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        stop_test();
    end
endmodule // testbench
bind wwdr_top wwdr_asserts i_asserts (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_clear_in(wdt_clear_in),
    .timeout_pulse(timeout_pulse), .window_open(window_open), .irq(irq));
`default_nettype wire
